// ### design/ued_pkg.sv
// constants shared by the endpoint memory and streaming channel logic
package ued_pkg;
   localparam int          MEM_BYTES  = 1440;
   localparam int          AW         = 11;
   localparam int          NUM_EP     = 7;
   localparam int          REC_BYTES  = 6;
   localparam int          NREQ       = 4;
   localparam int          NCH        = 2;
   localparam int          NSLOT      = 16;
   localparam logic [10:0] CFG_BASE   = 11'h54C;
   // requester order of the round-robin rotation
   localparam logic [1:0]  REQ_MCU    = 2'h0;
   localparam logic [1:0]  REQ_UBM    = 2'h1;
   localparam int          REQ_CH0    = 2;
   // apb map
   localparam logic [15:0] MEM_TOP    = 16'h1680;
   localparam logic [15:0] CODEC_OFF  = 16'h2000;
   localparam logic [11:0] CH0_PAGE   = 12'h201;
   localparam logic [11:0] CH1_PAGE   = 12'h202;
   localparam logic [3:0]  CH_CTL_OFF = 4'h0;
   localparam logic [3:0]  CH_SLT_OFF = 4'h4;
   localparam logic [3:0]  CH_STA_OFF = 4'h8;
   // channel control and status fields
   localparam int          CTL_EN     = 0;
   localparam int          CTL_DIR    = 1;
   localparam int          CTL_EP_LSB = 2;
   localparam int          EP_W       = 3;
   localparam int          STA_BUF    = 8;
   localparam int          STA_OVR    = 9;
   // endpoint record byte layout
   localparam int          REC_CFG    = 0;
   localparam int          REC_STX    = 1;
   localparam int          REC_STY    = 2;
   localparam int          REC_SIZE   = 3;
   localparam int          REC_CNTX   = 4;
   localparam int          REC_CNTY   = 5;
   localparam int          REC_DBL    = 0;
   localparam int          BUF_SHIFT  = 3;
   // codec framing
   localparam logic [1:0]  FMT_AC97   = 2'h0;
   localparam logic [1:0]  FMT_I2S    = 2'h1;
   localparam logic [1:0]  FMT_GP     = 2'h2;
   localparam logic [1:0]  FMT_RST    = FMT_AC97;
endpackage : ued_pkg

// ### design/ued_mem_arb.sv
// shared endpoint memory with fixed round-robin access slots
module ued_mem_arb (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic [3:0]           req,
   input  wire logic [3:0]           we,
   input  wire logic [3:0][10:0]     addr,
   input  wire logic [3:0][7:0]      wdata,
   output logic      [3:0]           gnt_reg,
   output logic      [7:0]           rdata,
   input  wire logic [1:0][10:0]     look_base,
   output logic      [1:0][5:0][7:0] look_data
);
   logic [1:0]  slot_reg;
   logic [1:0]  slot_next;
   logic [3:0]  gnt_next;
   logic        acc_we;
   logic [10:0] acc_addr;
   logic [7:0]  mem_reg  [ued_pkg::MEM_BYTES];
   logic [7:0]  mem_next [ued_pkg::MEM_BYTES];

   // one owner per cycle, rotating at a fixed rate
   always_comb
   begin
      slot_next = slot_reg + 2'h1;
      gnt_next  = 4'h1 << slot_next;
      acc_addr  = addr[slot_reg];
      acc_we    = req[slot_reg] & we[slot_reg];
      rdata     = (acc_addr < 11'(ued_pkg::MEM_BYTES)) ? mem_reg[acc_addr] : 8'h00;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         slot_reg <= 2'h0;
         gnt_reg  <= 4'h1;
      end
      else
      begin
         slot_reg <= slot_next;
         gnt_reg  <= gnt_next;
      end
   end

   // records and buffers in one 1440-byte array
   for (genvar i = 0; i < ued_pkg::MEM_BYTES; i++)
   begin : g_mem
      assign mem_next[i] = (acc_we && acc_addr == 11'(i)) ? wdata[slot_reg] : mem_reg[i];
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            mem_reg[i] <= 8'h00;
         else
            mem_reg[i] <= mem_next[i];
      end
   end

   // record taps for the channels
   for (genvar c = 0; c < ued_pkg::NCH; c++)
   begin : g_look
      for (genvar b = 0; b < ued_pkg::REC_BYTES; b++)
      begin : g_byte
         logic [10:0] idx;
         assign idx = look_base[c] + 11'(b);
         assign look_data[c][b] = (idx < 11'(ued_pkg::MEM_BYTES)) ? mem_reg[idx] : 8'h00;
      end
   end
endmodule : ued_mem_arb

// ### design/ued_chan.sv
// one streaming channel between endpoint buffers and codec slots
module ued_chan (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        run,
   input  wire logic        dir_in,
   input  wire logic [15:0] slot_mask,
   input  wire logic [5:0][7:0] rec,
   input  wire logic        slot_stb,
   input  wire logic [3:0]  slot_idx,
   input  wire logic [7:0]  rx_byte,
   input  wire logic        gnt,
   input  wire logic [7:0]  rdata,
   output logic             req_reg,
   output logic             we_reg,
   output logic [10:0]      addr_reg,
   output logic [7:0]       wdata_reg,
   output logic [7:0]       tx_reg,
   output logic             tx_stb_reg,
   output logic [7:0]       ptr_reg,
   output logic             buf_reg,
   output logic             ovr_reg
);
   typedef enum logic [2:0] {S_OFF, S_FETCH, S_HOLD, S_WAIT, S_WRITE} ued_chs_e;
   ued_chs_e    st_reg, st_next;
   logic        req_next, we_next, tx_stb_next, buf_next, ovr_next, hit, done;
   logic [10:0] addr_next;
   logic [7:0]  wdata_next, tx_next, ptr_next, hold_reg, hold_next, cnt, nptr, start;

   assign hit   = slot_stb & slot_mask[slot_idx];
   assign done  = req_reg & gnt;
   assign cnt   = buf_reg ? rec[ued_pkg::REC_CNTY] : rec[ued_pkg::REC_CNTX];
   assign start = buf_reg ? rec[ued_pkg::REC_STY] : rec[ued_pkg::REC_STX];
   assign nptr  = ptr_reg + 8'h01;

   always_comb
   begin
      st_next     = st_reg;
      req_next    = req_reg;
      we_next     = we_reg;
      addr_next   = addr_reg;
      wdata_next  = wdata_reg;
      tx_next     = tx_reg;
      tx_stb_next = 1'b0;
      ptr_next    = ptr_reg;
      buf_next    = buf_reg;
      hold_next   = hold_reg;
      ovr_next    = 1'b0;
      // buffer position from the selected endpoint record
      addr_next   = (11'(start) << ued_pkg::BUF_SHIFT) + 11'(ptr_reg);
      if (done)
      begin
         req_next = 1'b0;
         if (nptr >= cnt)
         begin
            ptr_next = 8'h00;
            buf_next = buf_reg ^ rec[ued_pkg::REC_CFG][ued_pkg::REC_DBL];
         end
         else
            ptr_next = nptr;
      end
      unique case (st_reg)
         S_OFF:
         begin
            ptr_next = 8'h00;
            buf_next = 1'b0;
            req_next = 1'b0;
            if (run)
               st_next = dir_in ? S_FETCH : S_WAIT;
         end
         S_FETCH:
         begin
            // read stays pending until its slot comes round
            req_next = ~done;
            we_next  = 1'b0;
            if (done)
            begin
               hold_next = rdata;
               st_next   = S_HOLD;
            end
            ovr_next = hit;
         end
         S_HOLD:
            if (hit)
            begin
               tx_next     = hold_reg; // buffer to codec
               tx_stb_next = 1'b1;
               st_next     = S_FETCH;
            end
         S_WAIT:
            if (hit)
            begin
               wdata_next = rx_byte; // codec to buffer
               we_next    = 1'b1;
               req_next   = 1'b1;
               st_next    = S_WRITE;
            end
         S_WRITE:
         begin
            if (done)
               st_next = S_WAIT;
            ovr_next = hit;
         end
      endcase
      if (!run)
      begin
         st_next  = S_OFF;
         req_next = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_reg     <= S_OFF;
         req_reg    <= 1'b0;
         we_reg     <= 1'b0;
         addr_reg   <= 11'h000;
         wdata_reg  <= 8'h00;
         tx_reg     <= 8'h00;
         tx_stb_reg <= 1'b0;
         ptr_reg    <= 8'h00;
         buf_reg    <= 1'b0;
         hold_reg   <= 8'h00;
         ovr_reg    <= 1'b0;
      end
      else
      begin
         st_reg     <= st_next;
         req_reg    <= req_next;
         we_reg     <= we_next;
         addr_reg   <= addr_next;
         wdata_reg  <= wdata_next;
         tx_reg     <= tx_next;
         tx_stb_reg <= tx_stb_next;
         ptr_reg    <= ptr_next;
         buf_reg    <= buf_next;
         hold_reg   <= hold_next;
         ovr_reg    <= ovr_next;
      end
   end
endmodule : ued_chan

// ### design/ued_top.sv
// endpoint memory, apb access and two codec streaming channels
//
// Local design decisions: the register offsets and the APB slave port.
module ued_top (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [15:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic             ubm_req,
   input  wire logic             ubm_we,
   input  wire logic [10:0]      ubm_addr,
   input  wire logic [7:0]       ubm_wdata,
   output logic      [7:0]       ubm_rdata,
   output logic                  ubm_ack,
   input  wire logic             codec_slot_stb,
   input  wire logic [3:0]       codec_slot,
   input  wire logic [7:0]       codec_rx_byte,
   output logic      [1:0][7:0]  codec_tx_byte,
   output logic      [1:0]       codec_tx_stb,
   output logic      [1:0]       codec_fmt
);
   localparam int NCH = ued_pkg::NCH;

   logic [31:0]           prdata_reg, prdata_next;
   logic                  pready_reg, pready_next, pslverr_reg, pslverr_next;
   logic [7:0]            ubm_rdata_reg, ubm_rdata_next;
   logic                  ubm_ack_reg, ubm_ack_next;
   logic [1:0]            fmt_reg, fmt_next;
   logic [NCH-1:0][7:0]   ctl_reg, ctl_next;
   logic [NCH-1:0][15:0]  slt_reg, slt_next;
   logic [NCH-1:0]        ovr_reg, ovr_next;
   logic [3:0]            m_req, m_we, gnt;
   logic [3:0][10:0]      m_addr;
   logic [3:0][7:0]       m_wdata;
   logic [7:0]            m_rdata;
   logic [1:0][10:0]      look_base;
   logic [1:0][5:0][7:0]  look_data;
   logic [NCH-1:0]        ch_run, ch_dir, ch_ovr, ch_buf, ch_req, ch_we, ch_stb;
   logic [NCH-1:0][10:0]  ch_addr;
   logic [NCH-1:0][7:0]   ch_wdata, ch_tx, ch_ptr;
   logic                  acc, mem_hit, ch_hit;
   logic                  ch_sel;

   assign acc     = psel & penable & ~pready_reg;
   assign mem_hit = paddr < ued_pkg::MEM_TOP;
   assign ch_hit  = (paddr[15:4] == ued_pkg::CH0_PAGE) || (paddr[15:4] == ued_pkg::CH1_PAGE);
   assign ch_sel  = paddr[15:4] == ued_pkg::CH1_PAGE;

   // requesters: microcontroller, buffer manager, then each channel
   always_comb
   begin
      m_req   = '0;
      m_we    = '0;
      m_addr  = '0;
      m_wdata = '0;
      m_req[ued_pkg::REQ_MCU]   = acc & mem_hit;
      m_we[ued_pkg::REQ_MCU]    = pwrite;
      m_addr[ued_pkg::REQ_MCU]  = paddr[12:2];
      m_wdata[ued_pkg::REQ_MCU] = pwdata[7:0];
      m_req[ued_pkg::REQ_UBM]   = ubm_req & ~ubm_ack_reg;
      m_we[ued_pkg::REQ_UBM]    = ubm_we;
      m_addr[ued_pkg::REQ_UBM]  = ubm_addr;
      m_wdata[ued_pkg::REQ_UBM] = ubm_wdata;
      for (int c = 0; c < NCH; c++)
      begin
         m_req[ued_pkg::REQ_CH0 + c]   = ch_req[c];
         m_we[ued_pkg::REQ_CH0 + c]    = ch_we[c];
         m_addr[ued_pkg::REQ_CH0 + c]  = ch_addr[c];
         m_wdata[ued_pkg::REQ_CH0 + c] = ch_wdata[c];
      end
   end

   ued_mem_arb u_mem (
      .pclk      (pclk),
      .presetn   (presetn),
      .req       (m_req),
      .we        (m_we),
      .addr      (m_addr),
      .wdata     (m_wdata),
      .gnt_reg   (gnt),
      .rdata     (m_rdata),
      .look_base (look_base),
      .look_data (look_data)
   );

   for (genvar c = 0; c < NCH; c++)
   begin : g_ch
      localparam int EP_W_L = ued_pkg::EP_W;
      logic [EP_W_L-1:0] ep;
      assign ep        = ctl_reg[c][ued_pkg::CTL_EP_LSB +: ued_pkg::EP_W];
      assign ch_dir[c] = ctl_reg[c][ued_pkg::CTL_DIR];
      // endpoint 0 is the control endpoint and never streams
      assign ch_run[c] = ctl_reg[c][ued_pkg::CTL_EN] & (ep != '0);
      // OUT records 1..7 first, then IN records 1..7, six bytes each
      assign look_base[c] = ued_pkg::CFG_BASE
                          + 11'(ued_pkg::REC_BYTES) * (11'(ep) - 11'h001
                          + (ch_dir[c] ? 11'(ued_pkg::NUM_EP) : 11'h000));

      ued_chan u_ch (
         .pclk       (pclk),
         .presetn    (presetn),
         .run        (ch_run[c]),
         .dir_in     (ch_dir[c]),
         .slot_mask  (slt_reg[c]),
         .rec        (look_data[c]),
         .slot_stb   (codec_slot_stb),
         .slot_idx   (codec_slot),
         .rx_byte    (codec_rx_byte),
         .gnt        (gnt[ued_pkg::REQ_CH0 + c]),
         .rdata      (m_rdata),
         .req_reg    (ch_req[c]),
         .we_reg     (ch_we[c]),
         .addr_reg   (ch_addr[c]),
         .wdata_reg  (ch_wdata[c]),
         .tx_reg     (ch_tx[c]),
         .tx_stb_reg (ch_stb[c]),
         .ptr_reg    (ch_ptr[c]),
         .buf_reg    (ch_buf[c]),
         .ovr_reg    (ch_ovr[c])
      );
   end

   // apb slave and register file
   always_comb
   begin
      prdata_next    = prdata_reg;
      pready_next    = 1'b0;
      pslverr_next   = 1'b0;
      fmt_next       = fmt_reg;
      ctl_next       = ctl_reg;
      slt_next       = slt_reg;
      ubm_ack_next   = 1'b0;
      ubm_rdata_next = ubm_rdata_reg;
      // sticky missed-slot flag, new event beats the clear
      ovr_next       = ovr_reg;
      if (acc)
      begin
         if (mem_hit)
         begin
            if (gnt[ued_pkg::REQ_MCU])
            begin
               pready_next = 1'b1;
               prdata_next = {24'h000000, m_rdata};
            end
         end
         else if (paddr == ued_pkg::CODEC_OFF)
         begin
            pready_next = 1'b1;
            prdata_next = {30'h0, fmt_reg};
            if (pwrite)
               fmt_next = pwdata[1:0];
         end
         else if (ch_hit && paddr[3:0] == ued_pkg::CH_CTL_OFF)
         begin
            pready_next = 1'b1;
            prdata_next = {24'h000000, ctl_reg[ch_sel]};
            if (pwrite)
               ctl_next[ch_sel] = pwdata[7:0];
         end
         else if (ch_hit && paddr[3:0] == ued_pkg::CH_SLT_OFF)
         begin
            pready_next = 1'b1;
            prdata_next = {16'h0000, slt_reg[ch_sel]};
            if (pwrite)
               slt_next[ch_sel] = pwdata[15:0];
         end
         else if (ch_hit && paddr[3:0] == ued_pkg::CH_STA_OFF)
         begin
            pready_next = 1'b1;
            prdata_next = {22'h0, ovr_reg[ch_sel], ch_buf[ch_sel], ch_ptr[ch_sel]};
            if (pwrite && pwdata[ued_pkg::STA_OVR])
               ovr_next[ch_sel] = 1'b0;
         end
         else
         begin
            pready_next  = 1'b1;
            pslverr_next = 1'b1;
            prdata_next  = 32'h00000000;
         end
      end
      for (int c = 0; c < NCH; c++)
         if (ch_ovr[c])
            ovr_next[c] = 1'b1;
      if (m_req[ued_pkg::REQ_UBM] && gnt[ued_pkg::REQ_UBM])
      begin
         ubm_ack_next   = 1'b1;
         ubm_rdata_next = m_rdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_reg    <= 32'h00000000;
         pready_reg    <= 1'b0;
         pslverr_reg   <= 1'b0;
         fmt_reg       <= ued_pkg::FMT_RST;
         ctl_reg       <= '0;
         slt_reg       <= '0;
         ovr_reg       <= '0;
         ubm_ack_reg   <= 1'b0;
         ubm_rdata_reg <= 8'h00;
      end
      else
      begin
         prdata_reg    <= prdata_next;
         pready_reg    <= pready_next;
         pslverr_reg   <= pslverr_next;
         fmt_reg       <= fmt_next;
         ctl_reg       <= ctl_next;
         slt_reg       <= slt_next;
         ovr_reg       <= ovr_next;
         ubm_ack_reg   <= ubm_ack_next;
         ubm_rdata_reg <= ubm_rdata_next;
      end
   end

   assign prdata        = prdata_reg;
   assign pready        = pready_reg;
   assign pslverr       = pslverr_reg;
   assign ubm_rdata     = ubm_rdata_reg;
   assign ubm_ack       = ubm_ack_reg;
   assign codec_tx_byte = ch_tx;
   assign codec_tx_stb  = ch_stb;
   assign codec_fmt     = fmt_reg;
endmodule : ued_top

// ### test/ued_assertions.sv
// checker for apb answers, buffer manager answers and codec strobes
module ued_assertions (
   input wire logic            pclk,
   input wire logic            presetn,
   input wire logic            psel,
   input wire logic            penable,
   input wire logic            pwrite,
   input wire logic [15:0]     paddr,
   input wire logic            pready,
   input wire logic            pslverr,
   input wire logic            ubm_req,
   input wire logic            ubm_ack,
   input wire logic            codec_slot_stb,
   input wire logic [1:0][7:0] codec_tx_byte,
   input wire logic [1:0]      codec_tx_stb,
   input wire logic [1:0]      codec_fmt
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_access;
      psel && $rose(penable);
   endsequence
   sequence s_ubm_start;
      $rose(ubm_req);
   endsequence
   a_apb_bound: assert property (s_access |-> ##[1:4] pready)
      else $error("apb access not answered in time");
   a_ready_cause: assert property (pready |-> $past(psel && penable) ##1 !pready)
      else $error("pready without access or longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr outside pready");
   a_ubm_bound: assert property (s_ubm_start |-> ##[1:4] ubm_ack)
      else $error("buffer manager not granted in time");
   a_ack_cause: assert property (ubm_ack |-> $past(ubm_req) ##1 !ubm_ack)
      else $error("ack without request or too long");
   a_tx_cause0: assert property (codec_tx_stb[0] |-> $past(codec_slot_stb))
      else $error("channel 0 strobe without codec slot");
   a_tx_cause1: assert property (codec_tx_stb[1] |-> $past(codec_slot_stb))
      else $error("channel 1 strobe without codec slot");
   a_tx_held0: assert property ($changed(codec_tx_byte[0]) |-> codec_tx_stb[0])
      else $error("channel 0 byte changed without strobe");
   a_tx_held1: assert property ($changed(codec_tx_byte[1]) |-> codec_tx_stb[1])
      else $error("channel 1 byte changed without strobe");
   a_fmt_write: assert property ($changed(codec_fmt) |-> $past(psel && pwrite && paddr == ued_pkg::CODEC_OFF))
      else $error("framing changed without a write");
endmodule : ued_assertions

bind ued_top ued_assertions chk (.*);

// ### test/ued_codec_model.sv
// codec side: strobes slots, offers rx bytes, collects tx bytes
module ued_codec_model (
   input  wire logic            pclk,
   output logic                 codec_slot_stb,
   output logic      [3:0]      codec_slot,
   output logic      [7:0]      codec_rx_byte,
   input  wire logic [1:0][7:0] codec_tx_byte,
   input  wire logic [1:0]      codec_tx_stb
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      codec_slot_stb = 1'b0;
      codec_slot     = 4'hF;
      codec_rx_byte  = 8'hFF;
   end
   // one slot both ways, then enough idle cycles to avoid overrun
   task slot(input logic [3:0] s, input logic [7:0] b, output logic [1:0] stb, output logic [1:0][7:0] tx);
      @(posedge pclk);
      codec_slot_stb <= 1'b1;
      codec_slot     <= s;
      codec_rx_byte  <= b;
      @(posedge pclk);
      codec_slot_stb <= 1'b0;
      codec_slot     <= ~s;
      codec_rx_byte  <= ~b;
      @(posedge pclk);
      stb = codec_tx_stb;
      tx  = codec_tx_byte;
      repeat (6) @(posedge pclk);
   endtask : slot
   // one slot held for two edges, a second strobe while the first is pending
   task burst(input logic [3:0] s, input logic [7:0] b);
      @(posedge pclk);
      codec_slot_stb <= 1'b1;
      codec_slot     <= s;
      codec_rx_byte  <= b;
      repeat (2) @(posedge pclk);
      codec_slot_stb <= 1'b0;
      codec_slot     <= ~s;
      codec_rx_byte  <= ~b;
      repeat (6) @(posedge pclk);
   endtask : burst
endmodule : ued_codec_model

// ### test/test_usb_endpoint_stream_dma.sv
// bench for endpoint memory, apb map and the two streaming channels
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
   $display("unexpected %s: expected %h seen %h", n, e, g); end end
module test_usb_endpoint_stream_dma;
   timeunit 1ns;
   timeprecision 1ns;
   logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [15:0]     paddr;
   logic [31:0]     pwdata, prdata;
   logic            ubm_req, ubm_we, ubm_ack;
   logic [10:0]     ubm_addr;
   logic [7:0]      ubm_wdata, ubm_rdata, codec_rx_byte;
   logic            codec_slot_stb;
   logic [3:0]      codec_slot;
   logic [1:0][7:0] codec_tx_byte;
   logic [1:0]      codec_tx_stb, codec_fmt;
   int              bad_count, n_tests;
   ued_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ubm_req(ubm_req), .ubm_we(ubm_we), .ubm_addr(ubm_addr), .ubm_wdata(ubm_wdata),
      .ubm_rdata(ubm_rdata), .ubm_ack(ubm_ack), .codec_slot_stb(codec_slot_stb),
      .codec_slot(codec_slot), .codec_rx_byte(codec_rx_byte), .codec_tx_byte(codec_tx_byte),
      .codec_tx_stb(codec_tx_stb), .codec_fmt(codec_fmt));
   ued_codec_model codec (.pclk(pclk), .codec_slot_stb(codec_slot_stb), .codec_slot(codec_slot),
      .codec_rx_byte(codec_rx_byte), .codec_tx_byte(codec_tx_byte), .codec_tx_stb(codec_tx_stb));
   task tally_and_finish;
      if (bad_count == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   task apb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk iff pready === 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [15:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task rd(input logic [15:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
   endtask : rd
   task ubm(input logic w, input logic [10:0] a, input logic [7:0] d, output logic [7:0] r);
      @(posedge pclk);
      ubm_req   <= 1'b1;
      ubm_we    <= w;
      ubm_addr  <= a;
      ubm_wdata <= d;
      @(posedge pclk iff ubm_ack === 1'b1);
      r = ubm_rdata;
      ubm_req   <= 1'b0;
      ubm_wdata <= ~d;
   endtask : ubm
   task rec(input logic [10:0] base, input logic [5:0][7:0] b);
      for (int k = 0; k < 6; k++)
         wr({3'h0, base + 11'(k), 2'h0}, {24'h0, b[k]});
   endtask : rec
   task t_fmt;
      logic [1:0]  codes [3] = '{ued_pkg::FMT_I2S, ued_pkg::FMT_GP, ued_pkg::FMT_AC97};
      logic [31:0] r;
      `CHK("fmt at reset", ued_pkg::FMT_RST, codec_fmt)
      for (int f = 0; f < 3; f++)
      begin
         wr(ued_pkg::CODEC_OFF, {30'h0, codes[f]});
         @(posedge pclk);
         `CHK("fmt port", codes[f], codec_fmt)
         rd(ued_pkg::CODEC_OFF, r);
         `CHK("fmt read", {30'h0, codes[f]}, r)
      end
   endtask : t_fmt
   task t_regs;
      logic [11:0] pg;
      logic [31:0] r;
      logic        e;
      for (int c = 0; c < 2; c++)
      begin
         pg = c ? ued_pkg::CH1_PAGE : ued_pkg::CH0_PAGE;
         wr({pg, ued_pkg::CH_CTL_OFF}, 32'h1E - 32'(c * 20));
         wr({pg, ued_pkg::CH_SLT_OFF}, 32'hC003 + 32'(c));
         rd({pg, ued_pkg::CH_CTL_OFF}, r);
         `CHK("ctl read", 32'h1E - 32'(c * 20), r)
         rd({pg, ued_pkg::CH_SLT_OFF}, r);
         `CHK("slot read", 32'hC003 + 32'(c), r)
      end
      apb(1'b0, ued_pkg::MEM_TOP, 32'h0, r, e);
      `CHK("past memory err", 1'b1, e)
      `CHK("past memory data", 32'h0, r)
   endtask : t_regs
   task t_mem;
      logic [7:0]  b;
      logic [31:0] r;
      wr(16'h0000, 32'hA5);
      wr(16'h167C, 32'h5A);
      ubm(1'b0, 11'h000, 8'h00, b);
      `CHK("ubm byte 0", 8'hA5, b)
      ubm(1'b0, 11'h59F, 8'h00, b);
      `CHK("ubm byte 1439", 8'h5A, b)
      ubm(1'b1, 11'h300, 8'hC3, b);
      rd(16'h0C00, r);
      `CHK("apb sees ubm write", 32'hC3, r)
      ubm(1'b0, 11'h5A0, 8'h00, b);
      `CHK("ubm past memory", 8'h00, b)
   endtask : t_mem
   task t_in;
      logic [1:0]      s;
      logic [1:0][7:0] t;
      logic [7:0]      exp [3] = '{8'h5C, 8'hE7, 8'h5C};
      // in endpoint 7, single buffer at 0x100 holding two bytes
      rec(ued_pkg::CFG_BASE + 11'd78, 48'h00_02_01_00_20_00);
      wr(16'h0400, 32'h5C);
      wr(16'h0404, 32'hE7);
      wr({ued_pkg::CH0_PAGE, ued_pkg::CH_SLT_OFF}, 32'h0004);
      wr({ued_pkg::CH0_PAGE, ued_pkg::CH_CTL_OFF}, 32'h1F);
      repeat (10) @(posedge pclk);
      codec.slot(4'h5, 8'h00, s, t);
      `CHK("unmasked slot", 2'b00, s)
      for (int k = 0; k < 3; k++)
      begin
         codec.slot(4'h2, 8'h00, s, t);
         `CHK("in strobes", 2'b01, s)
         `CHK("in byte", exp[k], t[0])
      end
   endtask : t_in
   task t_out;
      logic [1:0]      s;
      logic [1:0][7:0] t;
      logic [31:0]     r;
      logic [15:0]     ad [3] = '{16'h0800, 16'h0804, 16'h0820};
      logic [31:0]     dv [3] = '{32'h11, 32'h22, 32'h33};
      // out endpoint 1, double buffer at 0x200 and 0x208, two bytes each
      rec(ued_pkg::CFG_BASE, 48'h02_02_02_41_40_01);
      wr({ued_pkg::CH1_PAGE, ued_pkg::CH_SLT_OFF}, 32'h000C);
      wr({ued_pkg::CH1_PAGE, ued_pkg::CH_CTL_OFF}, 32'h05);
      codec.slot(4'h3, 8'h11, s, t);
      `CHK("out no tx", 2'b00, s)
      codec.slot(4'h2, 8'h22, s, t);
      `CHK("duplex tx byte", 8'hE7, t[0])
      codec.slot(4'h3, 8'h33, s, t);
      for (int k = 0; k < 3; k++)
      begin
         rd(ad[k], r);
         `CHK("out buffer byte", dv[k], r)
      end
      rd({ued_pkg::CH1_PAGE, ued_pkg::CH_STA_OFF}, r);
      `CHK("out status", 10'h101, r[9:0])
   endtask : t_out
   task t_ovr;
      logic [1:0]      s;
      logic [1:0][7:0] t;
      logic [31:0]     r;
      `CHK("ch1 tx idle", 8'h00, codec_tx_byte[1])
      codec.burst(4'h3, 8'h44);
      rd(16'h0824, r);
      `CHK("first of two strobes", 32'h44, r)
      rd({ued_pkg::CH1_PAGE, ued_pkg::CH_STA_OFF}, r);
      `CHK("overrun status", 10'h200, r[9:0])
      wr({ued_pkg::CH1_PAGE, ued_pkg::CH_STA_OFF}, 32'h200);
      rd({ued_pkg::CH1_PAGE, ued_pkg::CH_STA_OFF}, r);
      `CHK("overrun cleared", 10'h000, r[9:0])
      // channel 1 turned round to the in endpoint 7 buffer
      wr({ued_pkg::CH1_PAGE, ued_pkg::CH_CTL_OFF}, 32'h00);
      wr({ued_pkg::CH1_PAGE, ued_pkg::CH_CTL_OFF}, 32'h1F);
      repeat (8) @(posedge pclk);
      codec.slot(4'h3, 8'h00, s, t);
      `CHK("ch1 in strobes", 2'b10, s)
      `CHK("ch1 in byte", 8'h5C, t[1])
   endtask : t_ovr
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   initial
   begin
      repeat (6000) @(posedge pclk);
      bad_count++;
      tally_and_finish();
   end
   initial
   begin
      {psel, penable, pwrite, ubm_req, ubm_we, presetn} = '0;
      paddr = '0;
      pwdata = '0;
      ubm_addr = '0;
      ubm_wdata = '0;
      bad_count = 0;
      n_tests = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_fmt();
      t_regs();
      t_mem();
      t_in();
      t_out();
      t_ovr();
      tally_and_finish();
   end
endmodule : test_usb_endpoint_stream_dma
